// *** debug_cmd_pkg.sv ***
// Shared constants and types for the debug command execution block
`default_nettype none
package debug_cmd_pkg;
    // Command codes; the read command carries a register index in low bits
    localparam logic [7:0] CMD_NOP       = 8'h00;
    localparam logic [7:0] CMD_GO        = 8'h08;
    localparam logic [7:0] CMD_GO_UNTIL  = 8'h0c;
    localparam logic [7:0] CMD_READ_BASE = 8'h60;
    localparam logic [7:0] CMD_READ_MASK = 8'hf0;
    localparam int         IDX_W         = 4;
    localparam int         NBYTES        = 4;
    localparam logic [1:0] LAST_BYTE     = 2'h3;
    localparam logic [31:0] DATA_RESET   = 32'h0000_0000;
    // Implemented byte lanes per register index, one nibble each,
    // index 0 in the low nibble; bit n set means byte n is backed
    localparam logic [63:0] REG_BYTE_MASK = 64'hffff_ffff_3333_1111;

    // Controller states
    typedef enum logic [2:0] {
        st_idle,
        st_flush,
        st_refill,
        st_wait_leave,
        st_wait_return,
        st_read_cap,
        st_send
    } state_t;

    // Command byte strobe from the link decoder
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } cmd_t;

    // Whole state of the controller
    typedef struct packed {
        state_t             state;
        logic [31:0]        data;
        logic [1:0]         byte_cnt;
        logic               until_ack;
        logic [IDX_W-1:0]   reg_index;
        logic               flush;
        logic               prefetch;
        logic               resume;
        logic               ack;
        logic               illegal_resp;
        logic               illegal_flag;
        logic               tx_valid;
        logic [7:0]         tx_byte;
    } ctl_t;
endpackage : debug_cmd_pkg
`default_nettype wire

// *** debug_link_controller.sv ***
// Command execution for resume-until-halt, no-op and core register read
// What this block does
// - Resume-until-halt in debug mode leaves debug mode and starts the core.
// - The core pipeline is flushed and then refilled before code runs.
// - Prefetch starts at the current program counter, with host updates kept.
// - With ack enabled, the resume ack pulse waits for re-entry to debug mode.
// - The wait for the resume ack has no timeout and may last forever.
// - Resume outside debug mode gives an illegal response and sets the flag.
// - With ack disabled, resume-until-halt behaves exactly like plain resume.
// - The no-op command changes no state at all.
// - The read command byte is base 0x60 plus the register index.
// - A register read returns 32 bits as four bytes unless a link sync ends it first.
// - Byte positions without implemented bits read back as zero.
`timescale 1ns/100ps
`default_nettype none
module debug_link_controller (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // Command side from the link decoder
    input  wire debug_cmd_pkg::cmd_t   cmd,
    input  wire logic                  ack_enable,
    input  wire logic                  sync_abort,
    input  wire logic                  illegal_clear,
    // Core side
    input  wire logic                  debug_active,
    input  wire logic [31:0]           core_reg_rdata,
    output logic [debug_cmd_pkg::IDX_W-1:0] core_register_index,
    output logic                       pipe_flush,
    output logic                       prefetch_start,
    output logic                       core_resume,
    // Answer side toward the link
    output logic                       ack_pulse,
    output logic                       illegal_resp,
    output logic                       illegal_command_flag,
    output logic                       tx_valid,
    output logic [7:0]                 tx_byte,
    input  wire logic                  tx_ready
);

    // Read command decode, shared by the next-state logic and checks
    function automatic logic is_read(input logic [7:0] code);
        return (code & debug_cmd_pkg::CMD_READ_MASK)
               == debug_cmd_pkg::CMD_READ_BASE;
    endfunction : is_read

    // Expand the implemented-lane nibble of an index into a bit mask
    function automatic logic [31:0] lane_mask(
        input logic [debug_cmd_pkg::IDX_W-1:0] idx);
        logic [3:0]  nib;
        logic [31:0] m;
        nib = 4'h0;
        m   = 32'h0000_0000;
        nib = debug_cmd_pkg::REG_BYTE_MASK[idx*4 +: 4];
        for (int b = 0; b < debug_cmd_pkg::NBYTES; b++) begin
            m[b*8 +: 8] = {8{nib[b]}};
        end
        return m;
    endfunction : lane_mask

    debug_cmd_pkg::ctl_t state_reg;
    debug_cmd_pkg::ctl_t state_next;
    logic                cmd_go_any;
    logic                cmd_rd;
    logic                cmd_bg;

    // Command classes seen in idle
    assign cmd_go_any = cmd.valid &&
                        (cmd.code == debug_cmd_pkg::CMD_GO ||
                         cmd.code == debug_cmd_pkg::CMD_GO_UNTIL);
    assign cmd_rd     = cmd.valid && is_read(cmd.code);
    assign cmd_bg     = cmd_go_any || cmd_rd;

    // Next-state logic; pulses default low every cycle
    always_comb begin
        state_next              = state_reg;
        state_next.flush        = 1'b0;
        state_next.prefetch     = 1'b0;
        state_next.resume       = 1'b0;
        state_next.ack          = 1'b0;
        state_next.illegal_resp = 1'b0;
        // Clear first so that a set in the same cycle wins
        if (illegal_clear) begin
            state_next.illegal_flag = 1'b0;
        end
        case (state_reg.state)
            debug_cmd_pkg::st_idle: begin
                if (cmd_bg && !debug_active) begin
                    state_next.illegal_resp = 1'b1;
                    state_next.illegal_flag = 1'b1;
                end else if (cmd_go_any) begin
                    state_next.state     = debug_cmd_pkg::st_flush;
                    state_next.flush     = 1'b1;
                    state_next.until_ack = ack_enable &&
                        (cmd.code == debug_cmd_pkg::CMD_GO_UNTIL);
                // index from low bits of command
                end else if (cmd_rd) begin
                    state_next.state     = debug_cmd_pkg::st_read_cap;
                    state_next.reg_index =
                        cmd.code[debug_cmd_pkg::IDX_W-1:0];
                end
                // no-op and unknown codes fall through untouched
            end
            debug_cmd_pkg::st_flush: begin
                state_next.state    = debug_cmd_pkg::st_refill;
                state_next.prefetch = 1'b1;
                state_next.resume   = 1'b1;
            end
            debug_cmd_pkg::st_refill: begin
                if (state_reg.until_ack) begin
                    state_next.state = debug_cmd_pkg::st_wait_leave;
                end else begin
                    state_next.state = debug_cmd_pkg::st_idle;
                    state_next.ack   = ack_enable;
                end
            end
            debug_cmd_pkg::st_wait_leave: begin
                // Core must drop out of debug mode before a return counts
                if (!debug_active) begin
                    state_next.state = debug_cmd_pkg::st_wait_return;
                end
            end
            debug_cmd_pkg::st_wait_return: begin
                // ack only on return to debug mode
                if (debug_active) begin
                    state_next.state = debug_cmd_pkg::st_idle;
                    state_next.ack   = 1'b1;
                end
            end
            debug_cmd_pkg::st_read_cap: begin
                state_next.data     = core_reg_rdata &
                                      lane_mask(state_reg.reg_index);
                // ack together with the first byte, most significant byte first
                state_next.ack      = ack_enable;
                state_next.state    = debug_cmd_pkg::st_send;
                state_next.byte_cnt = 2'h0;
                state_next.tx_valid = 1'b1;
                // Top byte of the masked word just captured
                state_next.tx_byte  = state_next.data[31:24];
            end
            debug_cmd_pkg::st_send: begin
                if (tx_ready) begin
                    if (state_reg.byte_cnt == debug_cmd_pkg::LAST_BYTE) begin
                        state_next.state    = debug_cmd_pkg::st_idle;
                        state_next.tx_valid = 1'b0;
                    end else begin
                        state_next.data     = {state_reg.data[23:0], 8'h00};
                        state_next.tx_byte  = state_reg.data[23:16];
                        state_next.byte_cnt = state_reg.byte_cnt + 2'h1;
                    end
                end
            end
            default: begin
                state_next.state = debug_cmd_pkg::st_idle;
            end
        endcase
        // link sync ends any pending command
        if (sync_abort && state_reg.state != debug_cmd_pkg::st_idle) begin
            state_next.state    = debug_cmd_pkg::st_idle;
            state_next.tx_valid = 1'b0;
            state_next.ack      = 1'b0;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg              <= '0;
            state_reg.state        <= debug_cmd_pkg::st_idle;
            state_reg.data         <= debug_cmd_pkg::DATA_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state flops
    assign core_register_index  = state_reg.reg_index;
    assign pipe_flush           = state_reg.flush;
    assign prefetch_start       = state_reg.prefetch;
    assign core_resume          = state_reg.resume;
    assign ack_pulse            = state_reg.ack;
    assign illegal_resp         = state_reg.illegal_resp;
    assign illegal_command_flag = state_reg.illegal_flag;
    assign tx_valid             = state_reg.tx_valid;
    assign tx_byte              = state_reg.tx_byte;

    // Checks on the command sequences
    sequence s_resume_taken;
        state_reg.state == debug_cmd_pkg::st_idle && cmd_go_any &&
        debug_active;
    endsequence

    sequence s_flush_then_refill;
        pipe_flush && !prefetch_start ##1 prefetch_start && !pipe_flush;
    endsequence

    property p_illegal_resume;
        @(posedge ref_clk) disable iff (!rstn)
        state_reg.state == debug_cmd_pkg::st_idle && cmd.valid &&
        cmd.code == debug_cmd_pkg::CMD_GO_UNTIL && !debug_active
        |=> illegal_resp && illegal_command_flag &&
            state_reg.state == debug_cmd_pkg::st_idle;
    endproperty
    a_illegal_resume: assert property (p_illegal_resume)
        else $error("illegal resume not reported");

    property p_flush_refill;
        @(posedge ref_clk) disable iff (!rstn)
        s_resume_taken |=> s_flush_then_refill;
    endproperty
    a_flush_refill: assert property (p_flush_refill)
        else $error("flush and refill out of order");

    property p_resume_with_prefetch;
        @(posedge ref_clk) disable iff (!rstn)
        core_resume == prefetch_start;
    endproperty
    a_resume_with_prefetch: assert property (p_resume_with_prefetch)
        else $error("resume without prefetch from PC");

    property p_resume_starts_core;
        @(posedge ref_clk) disable iff (!rstn)
        s_resume_taken |-> ##2 core_resume;
    endproperty
    a_resume_starts_core: assert property (p_resume_starts_core)
        else $error("core not restarted after resume");

    property p_ack_on_return;
        @(posedge ref_clk) disable iff (!rstn)
        state_reg.state == debug_cmd_pkg::st_wait_return && !sync_abort
        |=> (ack_pulse == $past(debug_active));
    endproperty
    a_ack_on_return: assert property (p_ack_on_return)
        else $error("resume ack not tied to debug re-entry");

    property p_no_timeout;
        @(posedge ref_clk) disable iff (!rstn)
        state_reg.state == debug_cmd_pkg::st_wait_return &&
        !debug_active && !sync_abort
        |=> state_reg.state == debug_cmd_pkg::st_wait_return;
    endproperty
    a_no_timeout: assert property (p_no_timeout)
        else $error("resume wait left without cause");

    property p_until_as_go;
        @(posedge ref_clk) disable iff (!rstn)
        s_resume_taken ##0 !ack_enable ##1 !sync_abort [*2]
        |=> state_reg.state == debug_cmd_pkg::st_idle && !ack_pulse;
    endproperty
    a_until_as_go: assert property (p_until_as_go)
        else $error("resume without handshake did not act as plain go");

    property p_nop_quiet;
        @(posedge ref_clk) disable iff (!rstn)
        state_reg.state == debug_cmd_pkg::st_idle && cmd.valid &&
        cmd.code == debug_cmd_pkg::CMD_NOP && !illegal_clear
        |=> state_reg.state == debug_cmd_pkg::st_idle &&
            $stable(state_reg.reg_index) &&
            $stable(illegal_command_flag) && !ack_pulse && !core_resume;
    endproperty
    a_nop_quiet: assert property (p_nop_quiet)
        else $error("no-op changed state");

    property p_read_index;
        @(posedge ref_clk) disable iff (!rstn)
        state_reg.state == debug_cmd_pkg::st_idle && cmd_rd && debug_active
        |=> core_register_index == $past(cmd.code[3:0]);
    endproperty
    a_read_index: assert property (p_read_index)
        else $error("register index not taken from command");

    property p_zero_lanes;
        @(posedge ref_clk) disable iff (!rstn)
        state_reg.state == debug_cmd_pkg::st_read_cap
        |=> (state_reg.data & ~lane_mask(state_reg.reg_index)) == 32'h0;
    endproperty
    a_zero_lanes: assert property (p_zero_lanes)
        else $error("unimplemented byte not zero");

    property p_msb_first;
        @(posedge ref_clk) disable iff (!rstn)
        state_reg.state == debug_cmd_pkg::st_send && tx_ready &&
        state_reg.byte_cnt != debug_cmd_pkg::LAST_BYTE && !sync_abort
        |=> tx_valid && tx_byte == $past(state_reg.data[23:16]);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("result byte order wrong");

    property p_four_bytes;
        @(posedge ref_clk) disable iff (!rstn)
        state_reg.state == debug_cmd_pkg::st_send && tx_ready &&
        state_reg.byte_cnt == debug_cmd_pkg::LAST_BYTE
        |=> !tx_valid && state_reg.state == debug_cmd_pkg::st_idle;
    endproperty
    a_four_bytes: assert property (p_four_bytes)
        else $error("read did not end after four bytes");

endmodule : debug_link_controller
`default_nettype wire

// *** debug_cmd_pkg_end.sv ***
// Intentionally empty companion file
`default_nettype none
`default_nettype wire

// *** debug_host_model.sv ***
// Host side of the debug link: takes result bytes, may stall
`timescale 1ns/100ps
`default_nettype none
module debug_host_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // Result bytes from the device
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_byte,
    output var  logic        tx_ready,
    // Test controls and observations
    input  wire logic        stall,
    output var  logic [31:0] word,
    output var  int          nbytes
);
    int seed = 32'hbda14f31;

    // Ready moves only on the falling edge, away from sampling
    always @(negedge ref_clk) begin
        tx_ready <= !stall || ($random(seed) & 1);
    end

    // all four bytes taken, first in is most significant
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            word   <= '0;
            nbytes <= 0;
        end else if (tx_valid && tx_ready) begin
            word   <= {word[23:0], tx_byte};
            nbytes <= nbytes + 1;
        end
    end
endmodule : debug_host_model
`default_nettype wire

// *** test_debug_link_controller.sv ***
// Self-checking bench for the debug command execution block
`timescale 1ns/100ps
`default_nettype none
module test_debug_link_controller;
    logic                ref_clk        = 1'b0;
    logic                rstn           = 1'b0;
    debug_cmd_pkg::cmd_t cmd            = '0;
    logic                ack_enable     = 1'b1;
    logic                sync_abort     = 1'b0;
    logic                illegal_clear  = 1'b0;
    logic                debug_active   = 1'b1;
    logic [31:0]         core_reg_rdata = '0;
    logic                stall          = 1'b0;
    logic [3:0]          core_register_index;
    logic                pipe_flush;
    logic                prefetch_start;
    logic                core_resume;
    logic                ack_pulse;
    logic                illegal_resp;
    logic                illegal_command_flag;
    logic                tx_valid;
    logic                tx_ready;
    logic [7:0]          tx_byte;
    logic [31:0]         host_word;
    int                  host_bytes;
    int                  fail_count      = 0;
    int                  samples_checked = 0;
    int                  seed            = 32'hbda14f31;

    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    debug_link_controller dut (
        .ref_clk(ref_clk), .rstn(rstn), .cmd(cmd),
        .ack_enable(ack_enable), .sync_abort(sync_abort),
        .illegal_clear(illegal_clear), .debug_active(debug_active),
        .core_reg_rdata(core_reg_rdata),
        .core_register_index(core_register_index),
        .pipe_flush(pipe_flush), .prefetch_start(prefetch_start),
        .core_resume(core_resume), .ack_pulse(ack_pulse),
        .illegal_resp(illegal_resp),
        .illegal_command_flag(illegal_command_flag),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready)
    );

    debug_host_model host (
        .ref_clk(ref_clk), .rstn(rstn), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready), .stall(stall),
        .word(host_word), .nbytes(host_bytes)
    );

    // Verdict and end of run
    task automatic results();
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    // Value compare, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic step();
        @(negedge ref_clk);
    endtask : step

    // One-cycle command strobe, launched off the falling edge
    task automatic issue(input logic [7:0] code);
        cmd = '{valid: 1'b1, code: code};
        step();
        cmd.valid = 1'b0;
    endtask : issue

    // Unbacked byte lanes read as zero
    function automatic logic [31:0] exp_read(input logic [3:0] idx,
                                             input logic [31:0] d);
        logic [3:0]  lanes;
        logic [31:0] r;
        lanes = debug_cmd_pkg::REG_BYTE_MASK[idx*4 +: 4];
        for (int b = 0; b < 4; b++) begin
            r[b*8 +: 8] = lanes[b] ? d[b*8 +: 8] : 8'h00;
        end
        return r;
    endfunction : exp_read

    // Register read with random data, ack mode and host stalls
    task automatic do_read(input logic [3:0] idx);
        int n;
        core_reg_rdata = $random(seed);
        ack_enable = 1'($random(seed));
        stall = 1'($random(seed));
        n = host_bytes;
        issue(8'h60 + {4'h0, idx});
        chk(core_register_index, idx);
        step();
        chk(ack_pulse, ack_enable);
        chk(tx_valid, 1'b1);
        for (int i = 0; i < 200 && host_bytes != n + 4; i++) begin
            step();
        end
        chk(host_bytes - n, 4);
        if (host_bytes != n + 4) begin
            results();
        end
        chk(host_word, exp_read(idx, core_reg_rdata));
        step();
        chk(tx_valid, 1'b0);
    endtask : do_read

    // Resume sequence; a long stay outside debug mode, then re-entry
    task automatic run_go(input logic [7:0] code, input logic en,
                          input logic abort);
        ack_enable = en;
        issue(code);
        chk(pipe_flush, 1'b1);
        chk(core_resume, 1'b0);
        step();
        chk(core_resume, 1'b1);
        chk(prefetch_start, 1'b1);
        debug_active = 1'b0;
        step();
        chk(ack_pulse, en && code == debug_cmd_pkg::CMD_GO);
        sync_abort = abort;
        for (int i = 0; i < 40; i++) begin
            step();
            sync_abort = 1'b0;
            chk(ack_pulse, 1'b0);
        end
        debug_active = 1'b1;
        step();
        chk(ack_pulse, en && !abort
            && code == debug_cmd_pkg::CMD_GO_UNTIL);
        step();
        chk(ack_pulse, 1'b0);
    endtask : run_go

    // Main sequence
    initial begin
        logic [7:0] bad [3];
        bad = '{8'h0c, 8'h08, 8'h6a};
        repeat (4) step();
        rstn = 1'b1;
        chk({pipe_flush, core_resume, ack_pulse, tx_valid}, 4'h0);
        for (int i = 0; i < 24; i++) begin
            do_read(i < 16 ? i[3:0] : 4'($random(seed)));
        end
        run_go(debug_cmd_pkg::CMD_GO, 1'b1, 1'b0);
        run_go(debug_cmd_pkg::CMD_GO, 1'b0, 1'b0);
        run_go(debug_cmd_pkg::CMD_GO_UNTIL, 1'b0, 1'b0);
        run_go(debug_cmd_pkg::CMD_GO_UNTIL, 1'b1, 1'b0);
        run_go(debug_cmd_pkg::CMD_GO_UNTIL, 1'b1, 1'b1);
        // Outside debug mode, then a filler command with the flag set
        foreach (bad[k]) begin
            step();
            debug_active = 1'b0;
            // Last pass clears in the same cycle; the set must win
            illegal_clear = (k == 2);
            issue(bad[k]);
            illegal_clear = 1'b0;
            chk(illegal_resp, 1'b1);
            chk(illegal_command_flag, 1'b1);
            debug_active = 1'b1;
            issue(debug_cmd_pkg::CMD_NOP);
            repeat (4) begin
                step();
                chk({illegal_command_flag, illegal_resp}, 2'h2);
                chk({pipe_flush, core_resume, ack_pulse, tx_valid},
                    4'h0);
            end
            illegal_clear = 1'b1;
            step();
            illegal_clear = 1'b0;
            chk(illegal_command_flag, 1'b0);
        end
        results();
    end
endmodule : test_debug_link_controller
`default_nettype wire
